// ==== rtl/cfd_chip_fault_diag.sv ====
// Chip-level fault supervision: masks, latched diagnostic bits, thermal and
// supply fault responses, serial framing check and the open-drain fault pin.
// Assumes resetn is the logic supply monitor, pins other than comparators are
// synchronous, and diagReadDone pulses when a full diagnostic read completes.
`timescale 1ns/100ps
// How it works
// - Mask bits disable all but two diagnostics
// - Masked diagnostic sets no state or flag
// - Fault bits latch until read or reset
// - Warning sets flag; direct mode pulls low
// - Indirect warning: none, or four-period repeating pulses
// - Warning never disables gate drives
// - Steady low releases now; pulses finish
// - Overtemp: flag; direct/stop-on-fault forces drives off
// - Indirect overtemp without stop: four-period repeating pulses
// - Indirect mode without stop-on-fault: overtemp disables nothing
// - Drives wait for supply-on; supply-off flags undervoltage
// - Undervoltage: steady low, PWM input ignored
// - Undervoltage removal re-enables; flag stays latched
// - Undervoltage mask disables the supply monitor
// - Logic reset disables outputs, resets everything
// - After reset, common and reset flags set
// - Bad edge count frame writes nothing
// - Framing error keeps diag, sets flags
// - Top diag bit is OR of fault bits
// - Pulse: rest of period plus count, repeat
// - Direct mode: low whenever fault present
module cfd_chip_fault_diag (
    input  wire logic                  ref_clk,
    input  wire logic                  resetn,
    input  wire cfd_pkg::cfd_comp_type compRaw,
    input  wire cfd_pkg::cfd_mask_type faultMask,
    input  wire logic                  directMode,
    input  wire logic                  stop_on_fault_enable,
    input  wire logic                  pwmIn,
    input  wire logic                  shiftClk,
    input  wire logic                  serial_strobe_n,
    input  wire logic                  diagReadDone,
    output cfd_pkg::cfd_diag_type      diagOut,
    output logic                       fault_out_n,
    output logic                       faultOutNOe,
    output logic                       gateDriveEnable,
    output logic                       pwmIgnore,
    output logic                       frameWrite
);
    import cfd_pkg::*;

    cfd_comp_type comp;
    cfd_diag_type diag_q;
    cfd_diag_type diag_d;
    logic         supplyOk_q;
    logic         supplyOk_d;
    logic         pwmPrev_q;
    logic         pwmPrev_d;
    logic         shiftPrev_q;
    logic         shiftPrev_d;
    logic         strobePrev_q;
    logic         strobePrev_d;
    logic [4:0]   edgeCount_q;
    logic [4:0]   edgeCount_d;
    logic         frameWrite_q;
    logic         frameWrite_d;
    logic         faultOe_q;
    logic         faultOe_d;
    logic         gateEn_q;
    logic         gateEn_d;
    logic         pwmIgnore_q;
    logic         pwmIgnore_d;
    logic         twCond;
    logic         otCond;
    logic         uvTrip;
    logic         uvFault;
    logic         otStops;
    logic         pulseReq;
    logic         pulseLow;
    logic         periodTick;
    logic         strobeRise;
    logic         frameErr;
    logic         frameOk;
    logic         clearDiag;

    // Any latched fault bit, excluding the common flag itself
    function automatic logic anyFault(input cfd_diag_type d);
        anyFault = d.porFlag | d.serialErrorFlag | d.supplyUndervoltageFlag
                 | d.overtempFlag | d.tempWarningFlag;
    endfunction

    function automatic logic risingEdge(input logic now, input logic prev);
        risingEdge = now & ~prev;
    endfunction

    cfd_sync u_sync (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .rawIn   (compRaw),
        .syncOut (comp)
    );

    cfd_pulse_gen u_pulse (
        .ref_clk    (ref_clk),
        .resetn     (resetn),
        .periodTick (periodTick),
        .request    (pulseReq),
        .pulseLow   (pulseLow)
    );

    // Fault conditions, masked at the source so nothing downstream sees them
    always_comb begin
        twCond  = comp.aboveWarningTemp & ~faultMask.tempWarning;
        otCond  = comp.aboveShutdownTemp & ~faultMask.overtemp;
        // Masking the monitor leaves the supply treated as good
        uvTrip  = comp.belowSupplyOff & ~faultMask.supplyUndervoltage;
        uvFault = ~supplyOk_q & ~faultMask.supplyUndervoltage;
        otStops = otCond & (directMode | stop_on_fault_enable);
        periodTick = risingEdge(pwmIn, pwmPrev_q);
    end

    // Supply state: starts not ok so drives wait for the on comparator
    always_comb begin
        supplyOk_d = supplyOk_q;
        if (uvTrip) begin
            supplyOk_d = 1'h0;
        end else if (comp.aboveSupplyOn) begin
            supplyOk_d = 1'h1;
        end
    end

    // Serial frame checker: counts shift-clock edges while strobe is low
    always_comb begin
        pwmPrev_d    = pwmIn;
        shiftPrev_d  = shiftClk;
        strobePrev_d = serial_strobe_n;
        strobeRise   = risingEdge(serial_strobe_n, strobePrev_q);
        edgeCount_d  = edgeCount_q;
        if (!serial_strobe_n && strobePrev_q) begin
            edgeCount_d = 5'h0;
        end else if (!serial_strobe_n && risingEdge(shiftClk, shiftPrev_q)
                     && edgeCount_q != FRAME_EDGE_MAX) begin
            // Saturates one past a frame so too many edges stays visible
            edgeCount_d = edgeCount_q + 5'h1;
        end
        frameOk      = strobeRise && edgeCount_q == FRAME_EDGES;
        frameErr     = strobeRise && edgeCount_q != FRAME_EDGES;
        frameWrite_d = frameOk;
    end

    // Diagnostic register: set beats clear; bad frame never clears
    always_comb begin
        clearDiag = diagReadDone & ~frameErr;
        diag_d    = clearDiag ? DIAG_CLEAR : diag_q;
        if (twCond) begin
            diag_d.tempWarningFlag = 1'h1;
        end
        if (otCond) begin
            diag_d.overtempFlag = 1'h1;
        end
        if (uvTrip) begin
            diag_d.supplyUndervoltageFlag = 1'h1;
        end
        if (frameErr) begin
            diag_d.serialErrorFlag = 1'h1;
        end
        diag_d.anyFaultFlag = anyFault(diag_d);
    end

    // Fault pin, drive enable and PWM gating
    always_comb begin
        pulseReq = 1'h0;
        faultOe_d = PIN_RELEASE;
        if (uvFault) begin
            faultOe_d = PIN_DRIVE;
        end else if (directMode) begin
            if (twCond || otCond) begin
                faultOe_d = PIN_DRIVE;
            end
        end else if (otCond && stop_on_fault_enable) begin
            faultOe_d = PIN_DRIVE;
        end else begin
            // Warning without stop-on-fault stays silent in indirect modes
            pulseReq = otCond | (twCond & stop_on_fault_enable);
            if (pulseLow) begin
                faultOe_d = PIN_DRIVE;
            end
        end
        // Warning deliberately absent here: it never stops the motor
        gateEn_d    = ~uvFault & ~otStops;
        pwmIgnore_d = uvFault;
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            // Logic reset: outputs off, flags show that a reset happened
            diag_q       <= DIAG_POR_VALUE;
            supplyOk_q   <= 1'h0;
            pwmPrev_q    <= 1'h0;
            shiftPrev_q  <= 1'h0;
            strobePrev_q <= 1'h1;
            edgeCount_q  <= 5'h0;
            frameWrite_q <= 1'h0;
            faultOe_q    <= PIN_RELEASE;
            gateEn_q     <= 1'h0;
            pwmIgnore_q  <= 1'h1;
        end else begin
            diag_q       <= diag_d;
            supplyOk_q   <= supplyOk_d;
            pwmPrev_q    <= pwmPrev_d;
            shiftPrev_q  <= shiftPrev_d;
            strobePrev_q <= strobePrev_d;
            edgeCount_q  <= edgeCount_d;
            frameWrite_q <= frameWrite_d;
            faultOe_q    <= faultOe_d;
            gateEn_q     <= gateEn_d;
            pwmIgnore_q  <= pwmIgnore_d;
        end
    end

    // Pin data is always low; only the enable moves
    assign fault_out_n     = 1'h0;
    assign faultOutNOe     = faultOe_q;
    assign diagOut         = diag_q;
    assign gateDriveEnable = gateEn_q;
    assign pwmIgnore       = pwmIgnore_q;
    assign frameWrite      = frameWrite_q;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    sequence s_resetRelease;
        $rose(resetn);
    endsequence

    sequence s_badFrame;
        frameErr;
    endsequence

    a_mask_blocks_tw: assert property (
        faultMask.tempWarning && !clearDiag && !diag_q.tempWarningFlag
        |=> !diag_q.tempWarningFlag)
        else $error("masked warning set its flag");
    a_bits_hold_latched: assert property (
        diag_q.overtempFlag && !clearDiag |=> diag_q.overtempFlag)
        else $error("overtemp flag dropped without read");
    a_common_flag_or: assert property (
        diagOut.anyFaultFlag == anyFault(diagOut))
        else $error("common flag disagrees with fault bits");
    a_bad_frame_flags: assert property (
        s_badFrame |=> diag_q.serialErrorFlag && diag_q.anyFaultFlag && !frameWrite)
        else $error("framing error not flagged or frame written");
    a_uv_pin_low: assert property (
        uvFault |=> faultOutNOe == PIN_DRIVE && pwmIgnore && !gateDriveEnable)
        else $error("undervoltage did not hold pin low and drives off");
    a_ot_stops_drives: assert property (
        otCond && (directMode || stop_on_fault_enable)
        |=> !gateDriveEnable && faultOutNOe == PIN_DRIVE)
        else $error("overtemp did not stop drives");
    a_warn_no_action: assert property (
        twCond && !otCond && supplyOk_q && !faultMask.supplyUndervoltage
        |=> gateDriveEnable)
        else $error("warning disabled drives");
    a_esf0_no_disable: assert property (
        !stop_on_fault_enable && !directMode && !uvFault |=> gateDriveEnable)
        else $error("drives disabled without stop-on-fault");
    a_por_flags_set: assert property (
        s_resetRelease |-> diag_q.porFlag && diag_q.anyFaultFlag)
        else $error("reset flags missing after release");

endmodule

// ==== include/cfd_pkg.sv ====
// Shared types and constants for the chip fault diagnostics block.
// Assumes one 10 MHz clock and a synchronous active-low reset.
package cfd_pkg;

    // Fault pulse length in PWM periods for the thermal faults
    localparam logic [2:0] PULSE_PERIODS  = 3'h4;
    // Shift-clock rising edges in one well-formed serial frame
    localparam logic [4:0] FRAME_EDGES    = 5'h10;
    localparam logic [4:0] FRAME_EDGE_MAX = 5'h11;
    // Open-drain pin: enable low means the pin is pulled low
    localparam logic       PIN_DRIVE      = 1'h0;
    localparam logic       PIN_RELEASE    = 1'h1;

    typedef struct packed {
        logic anyFaultFlag;
        logic porFlag;
        logic serialErrorFlag;
        logic supplyUndervoltageFlag;
        logic overtempFlag;
        logic tempWarningFlag;
    } cfd_diag_type;

    typedef struct packed {
        logic supplyUndervoltage;
        logic overtemp;
        logic tempWarning;
    } cfd_mask_type;

    // Raw comparator outputs, asynchronous to ref_clk
    typedef struct packed {
        logic aboveSupplyOn;
        logic belowSupplyOff;
        logic aboveShutdownTemp;
        logic aboveWarningTemp;
    } cfd_comp_type;

    localparam cfd_diag_type DIAG_CLEAR     = '{default: 1'h0};
    localparam cfd_diag_type DIAG_POR_VALUE = '{anyFaultFlag: 1'h1, porFlag: 1'h1,
                                                default: 1'h0};

    typedef enum logic [1:0] {
        PULSE_IDLE,
        PULSE_LOW,
        PULSE_HIGH
    } cfd_pulse_state_type;

endpackage

// ==== rtl/cfd_sync.sv ====
// Two-stage synchroniser for the comparator levels.
// Assumes inputs are slow levels; an event narrower than one clock can be missed.
`timescale 1ns/100ps
module cfd_sync (
    input  wire logic                  ref_clk,
    input  wire logic                  resetn,
    input  wire cfd_pkg::cfd_comp_type rawIn,
    output cfd_pkg::cfd_comp_type      syncOut
);
    import cfd_pkg::*;

    cfd_comp_type firstStage_q;
    cfd_comp_type firstStage_d;
    cfd_comp_type syncOut_q;
    cfd_comp_type syncOut_d;

    // First stage feeds only the second one
    always_comb begin
        firstStage_d = rawIn;
        syncOut_d    = firstStage_q;
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            firstStage_q <= '{default: 1'h0};
            syncOut_q    <= '{default: 1'h0};
        end else begin
            firstStage_q <= firstStage_d;
            syncOut_q    <= syncOut_d;
        end
    end

    assign syncOut = syncOut_q;

endmodule

// ==== rtl/cfd_pulse_gen.sv ====
// Repeating fault pulse generator timed by PWM period starts.
// Assumes periodTick is a one-cycle pulse at each PWM period start.
`timescale 1ns/100ps
module cfd_pulse_gen (
    input  wire logic ref_clk,
    input  wire logic resetn,
    input  wire logic periodTick,
    input  wire logic request,
    output logic      pulseLow
);
    import cfd_pkg::*;

    cfd_pulse_state_type state_q;
    cfd_pulse_state_type state_d;
    logic [2:0]          count_q;
    logic [2:0]          count_d;

    always_comb begin
        state_d = state_q;
        count_d = count_q;
        case (state_q)
            PULSE_IDLE: begin
                // Goes low at once, rest of this period counts as extra
                if (request) begin
                    state_d = PULSE_LOW;
                    count_d = 3'h0;
                end
            end
            PULSE_LOW: begin
                // Low phase always finishes, even if the cause clears
                if (periodTick) begin
                    if (count_q == PULSE_PERIODS) begin
                        state_d = request ? PULSE_HIGH : PULSE_IDLE;
                        count_d = 3'h1;
                    end else begin
                        count_d = count_q + 3'h1;
                    end
                end
            end
            PULSE_HIGH: begin
                if (!request) begin
                    state_d = PULSE_IDLE;
                end else if (periodTick) begin
                    if (count_q == PULSE_PERIODS) begin
                        // Repeat starts on a period edge, so skip the remainder
                        state_d = PULSE_LOW;
                        count_d = 3'h1;
                    end else begin
                        count_d = count_q + 3'h1;
                    end
                end
            end
            default: begin
                state_d = PULSE_IDLE;
                count_d = 3'h0;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            state_q <= PULSE_IDLE;
            count_q <= 3'h0;
        end else begin
            state_q <= state_d;
            count_q <= count_d;
        end
    end

    assign pulseLow = (state_q == PULSE_LOW);

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    sequence s_pulseStart;
        state_q == PULSE_IDLE && request;
    endsequence

    a_pulse_goes_low: assert property (s_pulseStart |=> pulseLow)
        else $error("pulse did not start on request");
    a_pulse_holds_low: assert property (
        pulseLow && !(periodTick && count_q == PULSE_PERIODS) |=> pulseLow)
        else $error("pulse ended before its last period");
    a_pulse_high_stops: assert property (
        state_q == PULSE_HIGH && !request |=> state_q == PULSE_IDLE)
        else $error("repeat continued after cause cleared");

endmodule

// ==== sim/cfd_host_model.sv ====
// Host-side model: free-running PWM input and serial frames on request.
// Assumes the block samples all of these on rising ref_clk edges.
`timescale 1ns/100ps
module cfd_host_model (
    input  wire logic       ref_clk,
    input  wire logic [7:0] periodLen,
    output logic            pwmIn,
    output logic            shiftClk,
    output logic            serial_strobe_n
);
    int pwmCnt;

    initial begin
        pwmIn           = 1'h0;
        shiftClk        = 1'h0;
        serial_strobe_n = 1'h1;
        pwmCnt          = 0;
    end

    // Half duty; each rise starts a PWM period
    always @(negedge ref_clk) begin
        pwmCnt = (pwmCnt + 1 >= int'(periodLen)) ? 0 : pwmCnt + 1;
        pwmIn <= (pwmCnt < int'(periodLen) / 2);
    end

    // Shift clock stands still outside frames; one cycle high, one low
    task automatic send_frame(input int edges);
        @(negedge ref_clk) serial_strobe_n <= 1'h0;
        repeat (edges) begin
            @(negedge ref_clk) shiftClk <= 1'h1;
            @(negedge ref_clk) shiftClk <= 1'h0;
        end
        @(negedge ref_clk) serial_strobe_n <= 1'h1;
    endtask
endmodule

// ==== sim/tb_top.sv ====
// Self-checking bench for the chip fault diagnostics block.
// Assumes the host model for PWM and serial frames; inputs move at negedge.
`timescale 1ns/100ps
`define CHK(got, exp) begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
        n_mismatch++; \
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
    end \
end
module tb_top;
    import cfd_pkg::*;
    logic         ref_clk;
    logic         resetn;
    cfd_comp_type comp;
    cfd_mask_type mask;
    logic         directMode;
    logic         stopOnFault;
    logic         diagReadDone;
    logic [7:0]   period;
    logic         pwmIn;
    logic         shiftClk;
    logic         strobeN;
    cfd_diag_type diagOut;
    cfd_diag_type expDiag;
    logic         faultPin;
    logic         faultNOe;
    logic         gateOn;
    logic         pwmIgnore;
    logic         frameWrite;
    int           n_mismatch;
    int           checks_done;
    int           nWrites;
    int           len;
    int           w;
    logic [31:0]  seed;
    int           counts [5];

    cfd_host_model host (
        .ref_clk         (ref_clk),
        .periodLen       (period),
        .pwmIn           (pwmIn),
        .shiftClk        (shiftClk),
        .serial_strobe_n (strobeN)
    );

    cfd_chip_fault_diag dut (
        .ref_clk              (ref_clk),
        .resetn               (resetn),
        .compRaw              (comp),
        .faultMask            (mask),
        .directMode           (directMode),
        .stop_on_fault_enable (stopOnFault),
        .pwmIn                (pwmIn),
        .shiftClk             (shiftClk),
        .serial_strobe_n      (strobeN),
        .diagReadDone         (diagReadDone),
        .diagOut              (diagOut),
        .fault_out_n          (faultPin),
        .faultOutNOe          (faultNOe),
        .gateDriveEnable      (gateOn),
        .pwmIgnore            (pwmIgnore),
        .frameWrite           (frameWrite)
    );

    initial begin
        ref_clk = 1'h0;
        forever #50 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        if (frameWrite === 1'h1) nWrites++;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic void fixAny();
        expDiag.anyFaultFlag = |expDiag[4:0];
    endfunction

    task automatic close_out();
        $display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Model of the settled pin, drives and flags for steady conditions
    task automatic steady(input logic uv, input logic tw, input logic ot);
        logic stop;
        stop = ot & (directMode | stopOnFault);
        `CHK(faultNOe, !(uv | (tw & directMode) | stop))
        `CHK(gateOn, !(uv | stop))
        `CHK(pwmIgnore, uv)
        `CHK(faultPin, 1'h0)
        `CHK(diagOut, expDiag)
    endtask

    task automatic readDiag();
        @(negedge ref_clk) diagReadDone = 1'h1;
        @(negedge ref_clk) diagReadDone = 1'h0;
        expDiag = DIAG_CLEAR;
    endtask

    // Capped so a pin that never moves cannot hang the run
    task automatic countLvl(input logic lvl, output int n);
        n = 0;
        while (faultNOe === lvl && n < 300) begin
            n++;
            @(negedge ref_clk);
        end
    endtask

    // Repeating pulse; the second pulse must finish after the cause drops
    task automatic pulseCheck();
        countLvl(1'h1, len);
        `CHK(faultNOe, 1'h0)
        if (faultNOe !== 1'h0) close_out();
        `CHK(gateOn, 1'h1)
        countLvl(1'h0, len);
        `CHK(len >= 4 * period + 1 && len <= 5 * period + 1, 1'h1)
        countLvl(1'h1, len);
        `CHK(len, 4 * int'(period))
        comp.aboveWarningTemp  = 1'h0;
        comp.aboveShutdownTemp = 1'h0;
        countLvl(1'h0, len);
        `CHK(len, 4 * int'(period))
        countLvl(1'h1, len);
        `CHK(len, 300)
    endtask

    initial begin
        seed = xs(32'hd3518e0d);
        period = 8'h6 + 8'(seed[2:0]);
        comp = '0;
        mask = '0;
        directMode = 1'h1;
        stopOnFault = 1'h0;
        diagReadDone = 1'h0;
        resetn = 1'h0;
        n_mismatch = 0;
        checks_done = 0;
        nWrites = 0;
        repeat (5) @(negedge ref_clk);
        `CHK(diagOut, DIAG_POR_VALUE)
        `CHK(faultNOe, 1'h1)
        `CHK(gateOn, 1'h0)
        resetn = 1'h1;
        expDiag = DIAG_POR_VALUE;
        repeat (2) @(negedge ref_clk);
        steady(1'h1, 1'h0, 1'h0);
        comp.aboveSupplyOn = 1'h1;
        repeat (4) @(negedge ref_clk);
        steady(1'h0, 1'h0, 1'h0);
        readDiag();
        repeat (2) @(negedge ref_clk);
        steady(1'h0, 1'h0, 1'h0);
        // Undervoltage in indirect mode, then removal
        directMode = 1'h0;
        stopOnFault = seed[3];
        comp.belowSupplyOff = 1'h1;
        expDiag.supplyUndervoltageFlag = 1'h1;
        fixAny();
        repeat (4) @(negedge ref_clk);
        steady(1'h1, 1'h0, 1'h0);
        comp.belowSupplyOff = 1'h0;
        repeat (4) @(negedge ref_clk);
        steady(1'h0, 1'h0, 1'h0);
        // Bad frame with a read in the same cycle keeps the flags
        w = nWrites;
        fork
            host.send_frame(15);
            begin
                @(posedge strobeN);
                diagReadDone = 1'h1;
                @(negedge ref_clk);
                diagReadDone = 1'h0;
            end
        join
        expDiag.serialErrorFlag = 1'h1;
        fixAny();
        repeat (3) @(negedge ref_clk);
        `CHK(nWrites - w, 0)
        `CHK(diagOut, expDiag)
        seed = xs(seed);
        counts = '{16, 17, 0, 16, 14 + int'(seed[7:0]) % 5};
        foreach (counts[i]) begin
            readDiag();
            w = nWrites;
            host.send_frame(counts[i]);
            repeat (3) @(negedge ref_clk);
            `CHK(nWrites - w, int'(counts[i] == 16))
            expDiag.serialErrorFlag = (counts[i] != 16);
            fixAny();
            `CHK(diagOut, expDiag)
        end
        // Masked diagnostics stay silent
        readDiag();
        directMode = 1'h1;
        mask = 3'h7;
        comp = 4'hf;
        repeat (4) @(negedge ref_clk);
        steady(1'h0, 1'h0, 1'h0);
        // Let the masked comparators settle low before the masks drop
        comp = 4'h8;
        repeat (4) @(negedge ref_clk);
        mask = '0;
        // Thermal faults across all four mode combinations
        for (int m = 0; m < 4; m++) begin
            for (int k = 0; k < 2; k++) begin
                directMode = m[1];
                stopOnFault = m[0];
                comp.aboveWarningTemp = (k == 0);
                comp.aboveShutdownTemp = (k == 1);
                repeat (2) @(negedge ref_clk);
                if (directMode) `CHK(faultNOe, 1'h1)
                repeat (2) @(negedge ref_clk);
                expDiag.tempWarningFlag = (k == 0);
                expDiag.overtempFlag = (k == 1);
                fixAny();
                `CHK(diagOut, expDiag)
                if (!directMode && (stopOnFault == (k == 0))) begin
                    pulseCheck();
                end else begin
                    steady(1'h0, k == 0, k == 1);
                    comp.aboveWarningTemp = 1'h0;
                    comp.aboveShutdownTemp = 1'h0;
                    repeat (4) @(negedge ref_clk);
                    steady(1'h0, 1'h0, 1'h0);
                end
                readDiag();
            end
        end
        // Mid-run reset behaves as a fresh power-up
        resetn = 1'h0;
        repeat (2) @(negedge ref_clk);
        `CHK(diagOut, DIAG_POR_VALUE)
        `CHK(faultNOe, 1'h1)
        `CHK(gateOn, 1'h0)
        resetn = 1'h1;
        repeat (2) @(negedge ref_clk);
        expDiag = DIAG_POR_VALUE;
        steady(1'h1, 1'h0, 1'h0);
        repeat (4) @(negedge ref_clk);
        steady(1'h0, 1'h0, 1'h0);
        close_out();
    end
endmodule
